// ===== design/ack_buf_cfg.svh
// Behaviour
// - keep ack results of the earliest six unread transmitted async packets
// - each entry is one 32-bit word with ack, node, tag, tcode, tally
// - next entry appears only after both 16-bit halves were read
// - bits 27:24 hold ack code from receiver or local transmitter
// - stream and broadcast packets record complete code 0001b
// - bit 28 is the error flag, forming a five-bit result
// - accepted/busy results: 0_0001, 0_0010, 0_0100, 0_0101, 0_0110
// - rejection results: 0_1011, 0_1100, 0_1101, 0_1110, 0_1111
// - subaction gap before any ack records 1_0000
// - bad tcode records 1_0001 and flushes transmit buffer when enabled
// - bad format records 1_0010; unclassified error records 1_0011
// - bits 15:8 copy bits 15:8 of the packet's first word
// - tally starts at zero, rises per loaded ack, saturates at six
// - a read of the empty buffer returns all zeros
// - when six entries are held further results are discarded
// - bits 21:16 hold destination node; not valid for streams
// - missing or unverified ack sets error flag; tally still counts
// - busy acks load only after the busy retry limit expired
// - non-busy ack during automatic retry loads normally
`ifndef ACK_BUF_CFG_SVH
`define ACK_BUF_CFG_SVH

`define ACK_DEPTH        6
`define OFF_TX_ACK_STAT  12'h204
`define OFF_TX_PATH_CFG  12'h208
`define CFG_FLUSH_BIT    0
`define RES_COMPLETE     5'h01
`define RES_PENDING      5'h02
`define RES_BUSY_X       5'h04
`define RES_BUSY_A       5'h05
`define RES_BUSY_B       5'h06
`define RES_BUSY_TARDY   5'h0b
`define RES_CONFLICT     5'h0c
`define RES_DATA_ERR     5'h0d
`define RES_TYPE_ERR     5'h0e
`define RES_ADDR_ERR     5'h0f
`define RES_NO_REPLY     5'h10
`define RES_BAD_TCODE    5'h11
`define RES_BAD_FORMAT   5'h12
`define RES_UNCLASSIFIED 5'h13
`define ERR_BIT          28
`define CODE_HI          27
`define CODE_LO          24
`define NODE_HI          21
`define NODE_LO          16
`define TAG_HI           15
`define TAG_LO           8
`define TCODE_HI         7
`define TCODE_LO         4
`define TALLY_HI         2
`define TALLY_LO         0
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ===== design/ack_buf_pkg.sv
package ack_buf_pkg;
  typedef enum logic [1:0] {
    EV_ACK         = 2'b00,
    EV_NO_REPLY    = 2'b01,
    EV_BAD_TCODE   = 2'b10,
    EV_BAD_FORMAT  = 2'b11
  } tx_event_e;
  typedef enum logic [1:0] {
    HALF_NONE = 2'b00,
    HALF_LO   = 2'b01,
    HALF_HI   = 2'b10,
    HALF_BOTH = 2'b11
  } half_e;
endpackage

// ===== design/async_ack_tracking_buffer.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "ack_buf_cfg.svh"

module async_ack_tracking_buffer #(
  parameter int DEPTH = `ACK_DEPTH
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_ARST_N,
  // completion of one transmitted packet
  input  wire logic        I_TX_DONE,
  input  wire logic [1:0]  I_TX_EVENT,
  input  wire logic [3:0]  I_ACK_CODE,
  input  wire logic        I_ACK_BAD,
  input  wire logic        I_NO_ACK_EXPECTED,
  input  wire logic        I_RETRY_EXPIRED,
  input  wire logic [5:0]  I_TARGET_NODE,
  input  wire logic [7:0]  I_PACKET_TAG,
  input  wire logic [3:0]  I_TCODE,
  // axi4-lite slave
  input  wire logic [11:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [11:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic             O_TX_FLUSH
);

  // ******************************************************************
  // result encoding
  // ******************************************************************
  function automatic logic is_busy(input logic [4:0] r);
    is_busy = (r == `RES_BUSY_X) || (r == `RES_BUSY_A) ||
              (r == `RES_BUSY_B);
  endfunction

  function automatic logic [4:0] result_of(
    input logic [1:0] ev, input logic [3:0] code,
    input logic bad, input logic noack);
    unique case (ack_buf_pkg::tx_event_e'(ev))
      ack_buf_pkg::EV_ACK:
        if (noack)
          result_of = `RES_COMPLETE;
        else if (bad)
          result_of = `RES_UNCLASSIFIED;
        else
          result_of = {1'b0, code};
      ack_buf_pkg::EV_NO_REPLY:   result_of = `RES_NO_REPLY;
      ack_buf_pkg::EV_BAD_TCODE:  result_of = `RES_BAD_TCODE;
      ack_buf_pkg::EV_BAD_FORMAT: result_of = `RES_BAD_FORMAT;
    endcase
  endfunction

  // ******************************************************************
  // storage
  // ******************************************************************
  logic [27:0] entry_reg [DEPTH];
  logic [2:0]  rd_ptr_reg;
  logic [2:0]  wr_ptr_reg;
  logic [2:0]  tally_reg;
  logic [2:0]  tally_next;
  logic [1:0]  half_reg;
  logic        cfg_flush_reg;
  logic [4:0]  result;
  logic        load;
  logic        pop;

  function automatic logic [2:0] wrap_inc(input logic [2:0] p);
    wrap_inc = (p == 3'(DEPTH - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  assign result = result_of(I_TX_EVENT, I_ACK_CODE, I_ACK_BAD,
                            I_NO_ACK_EXPECTED);
  // busy answers wait for the retry limit so they cannot flood the buffer
  assign load = I_TX_DONE &&
                (!is_busy(result) || I_RETRY_EXPIRED) &&
                (tally_reg != 3'(DEPTH));
  assign pop  = (half_reg == ack_buf_pkg::HALF_BOTH) &&
                (tally_reg != 3'h0);

  always_comb begin
    tally_next = tally_reg;
    if (load && !pop)
      tally_next = tally_reg + 3'h1;
    else if (pop && !load)
      tally_next = tally_reg - 3'h1;
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tally_reg  <= 3'h0;
      rd_ptr_reg <= 3'h0;
      wr_ptr_reg <= 3'h0;
    end else begin
      tally_reg <= tally_next;
      if (load)
        wr_ptr_reg <= wrap_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= wrap_inc(rd_ptr_reg);
    end
  end

  // entry words carry no reset; the tally guards reading stale slots
  always_ff @(posedge I_REF_CLK) begin
    if (load)
      entry_reg[wr_ptr_reg] <= {result, 2'h0, I_TARGET_NODE,
                                I_PACKET_TAG, I_TCODE, 3'h0};
  end

  // ******************************************************************
  // status word
  // ******************************************************************
  function automatic logic [31:0] status_word(
    input logic [27:0] e, input logic [2:0] n);
    status_word = 32'h0;
    if (n != 3'h0) begin
      status_word[`ERR_BIT:`CODE_LO]  = e[27:23];
      status_word[`NODE_HI:`NODE_LO]  = e[20:15];
      status_word[`TAG_HI:`TAG_LO]    = e[14:7];
      status_word[`TCODE_HI:`TCODE_LO] = e[6:3];
      status_word[`TALLY_HI:`TALLY_LO] = n;
    end
  endfunction
  // entry bits: [27:23] result, [22:21] pad, [20:15] node, [14:7] tag,
  // [6:3] tcode; bits [2:0] unused and kept zero

  // ******************************************************************
  // axi4-lite slave
  // ******************************************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic do_write;
  logic do_read;
  logic [3:0] rd_strb;

  assign do_write = aw_held_reg && w_held_reg && !O_BVALID;
  assign do_read  = I_ARVALID && O_ARREADY;
  // a 16-bit half counts when its two byte lanes are read; axi reads have
  // no strobe, so a full word read counts as both halves at once
  assign rd_strb  = (I_ARADDR[1:0] == 2'b10) ? 4'b1100 : 4'b1111;

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 12'h0;
      O_AWREADY   <= 1'b0;
    end else begin
      O_AWREADY <= !aw_held_reg && !O_AWREADY && I_AWVALID;
      if (I_AWVALID && O_AWREADY) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= I_AWADDR;
      end else if (do_write)
        aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0;
      wstrb_reg  <= 4'h0;
      O_WREADY   <= 1'b0;
    end else begin
      O_WREADY <= !w_held_reg && !O_WREADY && I_WVALID;
      if (I_WVALID && O_WREADY) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= I_WDATA;
        wstrb_reg  <= I_WSTRB;
      end else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_BVALID      <= 1'b0;
      O_BRESP       <= `RESP_OKAY;
      cfg_flush_reg <= 1'b0;
    end else begin
      if (do_write) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= `RESP_OKAY;
        if (awaddr_reg[11:2] == `OFF_TX_PATH_CFG >> 2) begin
          if (wstrb_reg[0])
            cfg_flush_reg <= wdata_reg[`CFG_FLUSH_BIT];
        end else if (awaddr_reg[11:2] != `OFF_TX_ACK_STAT >> 2)
          O_BRESP <= `RESP_SLVERR;
      end else if (O_BVALID && I_BREADY)
        O_BVALID <= 1'b0;
    end
  end

  // flush pulse toward the transmit buffer on a bad tcode
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N)
      O_TX_FLUSH <= 1'b0;
    else
      O_TX_FLUSH <= I_TX_DONE && cfg_flush_reg &&
                    (result == `RES_BAD_TCODE);
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= `RESP_OKAY;
    end else begin
      O_ARREADY <= !O_ARREADY && !O_RVALID && I_ARVALID;
      if (do_read) begin
        O_RVALID <= 1'b1;
        O_RRESP  <= `RESP_OKAY;
        O_RDATA  <= 32'h0;
        if (I_ARADDR[11:2] == `OFF_TX_ACK_STAT >> 2)
          O_RDATA <= status_word(entry_reg[rd_ptr_reg], tally_reg);
        else if (I_ARADDR[11:2] == `OFF_TX_PATH_CFG >> 2)
          O_RDATA <= {31'h0, cfg_flush_reg};
        else
          O_RRESP <= `RESP_SLVERR;
      end else if (O_RVALID && I_RREADY)
        O_RVALID <= 1'b0;
    end
  end

  // half tracking: both halves must be seen before the entry advances
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N)
      half_reg <= ack_buf_pkg::HALF_NONE;
    else if (pop || tally_reg == 3'h0)
      half_reg <= ack_buf_pkg::HALF_NONE;
    else if (do_read && I_ARADDR[11:2] == `OFF_TX_ACK_STAT >> 2)
      half_reg <= half_reg | {rd_strb[3], rd_strb[0]};
  end

  // ******************************************************************
  // assertions
  // ******************************************************************
  property p_tally_max;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      tally_reg <= 3'(DEPTH);
  endproperty
  a_tally_max: assert property (p_tally_max)
    else $error("tally above depth");

  property p_full_drop;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      (tally_reg == 3'(DEPTH)) && !pop |=> tally_reg == 3'(DEPTH);
  endproperty
  a_full_drop: assert property (p_full_drop)
    else $error("full buffer changed without a read");

  property p_empty_zero;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      do_read && tally_reg == 3'h0 && !load &&
      I_ARADDR[11:2] == `OFF_TX_ACK_STAT >> 2 |=> O_RDATA == 32'h0;
  endproperty
  a_empty_zero: assert property (p_empty_zero)
    else $error("empty read not zero");

  property p_load_count;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      load && !pop |=> tally_reg == $past(tally_reg) + 3'h1;
  endproperty
  a_load_count: assert property (p_load_count)
    else $error("tally did not rise on load");

  property p_busy_hold;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      I_TX_DONE && is_busy(result) && !I_RETRY_EXPIRED |-> !load;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy ack loaded before retry limit");

  property p_half_no_pop;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      half_reg != ack_buf_pkg::HALF_BOTH |-> !pop;
  endproperty
  a_half_no_pop: assert property (p_half_no_pop)
    else $error("entry advanced after a single half");

  property p_no_reply;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      I_TX_EVENT == ack_buf_pkg::EV_NO_REPLY |-> result == `RES_NO_REPLY;
  endproperty
  a_no_reply: assert property (p_no_reply)
    else $error("missing ack result wrong");

  sequence s_bad_tcode;
    I_TX_DONE && cfg_flush_reg && I_TX_EVENT == ack_buf_pkg::EV_BAD_TCODE;
  endsequence
  property p_flush;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      s_bad_tcode |=> O_TX_FLUSH;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush not issued on bad tcode");

  property p_pop_count;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      pop && !load |=> tally_reg == $past(tally_reg) - 3'h1;
  endproperty
  a_pop_count: assert property (p_pop_count)
    else $error("tally did not fall after a full read");

  property p_complete_code;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      I_TX_EVENT == ack_buf_pkg::EV_ACK && I_NO_ACK_EXPECTED |->
        result == `RES_COMPLETE;
  endproperty
  a_complete_code: assert property (p_complete_code)
    else $error("stream or broadcast result not complete");

  property p_bad_ack_flag;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      I_TX_EVENT == ack_buf_pkg::EV_ACK && !I_NO_ACK_EXPECTED &&
      I_ACK_BAD |-> result == `RES_UNCLASSIFIED;
  endproperty
  a_bad_ack_flag: assert property (p_bad_ack_flag)
    else $error("unverified ack without error flag");

  property p_entry_code;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      load |=> entry_reg[$past(wr_ptr_reg)][27:23] == $past(result);
  endproperty
  a_entry_code: assert property (p_entry_code)
    else $error("stored result differs from the event");

  // a full-word read of a held entry must advance it one cycle later
  sequence s_full_read;
    do_read && I_ARADDR[11:2] == `OFF_TX_ACK_STAT >> 2 &&
    I_ARADDR[1:0] != 2'b10 && tally_reg != 3'h0 && !pop;
  endsequence
  property p_full_read_pops;
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
      s_full_read |=> pop;
  endproperty
  a_full_read_pops: assert property (p_full_read_pops)
    else $error("full read did not advance the entry");

endmodule

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`include "ack_buf_cfg.svh"

module tb_top;
  // ****************************************
  // stimulus and design
  // ****************************************
  logic        clk = 0, arst_n = 0, tx_done = 0, ack_bad = 0, no_ack = 0;
  logic        retry_exp = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0;
  logic [1:0]  tx_ev = 0, resp;
  logic [3:0]  ack_code = 0, tcode = 0, wstrb = 0;
  logic [5:0]  node = 0;
  logic [7:0]  tag = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic        awready, wready, bvalid, arready, rvalid, flush, flush_seen;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          bad_count = 0, n_tests = 0, i;

  initial forever #2 clk = ~clk;

  async_ack_tracking_buffer uut (
    .I_REF_CLK(clk), .I_ARST_N(arst_n), .I_TX_DONE(tx_done),
    .I_TX_EVENT(tx_ev), .I_ACK_CODE(ack_code), .I_ACK_BAD(ack_bad),
    .I_NO_ACK_EXPECTED(no_ack), .I_RETRY_EXPIRED(retry_exp),
    .I_TARGET_NODE(node), .I_PACKET_TAG(tag), .I_TCODE(tcode),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_TX_FLUSH(flush));

  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp_v);
    n_tests++;
    if (seen !== exp_v) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp_v, seen);
    end
  endtask

  // master holds each channel until its own ready edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic a_ok, w_ok;
    a_ok = 0;
    w_ok = 0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1;
    wstrb <= 4'hf; bready <= 1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk);
      if (!a_ok && awready === 1'b1) begin
        a_ok = 1;
        awvalid <= 0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 0;
  endtask

  // idle edges afterwards let the pop land before the next access
  task automatic axi_rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge clk);
    rd = rdata;
    resp = rresp;
    rready <= 0;
    repeat (4) @(posedge clk);
  endtask

  // node and tcode derived from the tag so entries differ
  task automatic tx(input logic [1:0] ev, input logic [3:0] c,
                    input logic b, na, re, input logic [7:0] t);
    @(posedge clk);
    tx_done <= 1; tx_ev <= ev; ack_code <= c; ack_bad <= b;
    no_ack <= na; retry_exp <= re; tag <= t;
    node <= t[5:0] ^ 6'h2a; tcode <= t[3:0];
    @(posedge clk);
    tx_done <= 0;
    #1 flush_seen = flush;
  endtask

  function automatic logic [31:0] ew(input logic [4:0] r,
                                     input logic [7:0] t,
                                     input logic [2:0] n);
    ew = {3'h0, r, 2'h0, t[5:0] ^ 6'h2a, t, t[3:0], 1'b0, n};
  endfunction

  task automatic pop_check(input logic [4:0] r, input logic [7:0] t,
                           input logic [2:0] n);
    axi_rd(`OFF_TX_ACK_STAT);
    check("entry", rd, ew(r, t, n));
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  logic [4:0] b1 [6] = '{5'h01, 5'h02, 5'h0b, 5'h0c, 5'h0d, 5'h0e};

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1;
    axi_rd(`OFF_TX_ACK_STAT);
    check("empty", rd, 32'h0);
    for (i = 0; i < 6; i++) tx(ack_buf_pkg::EV_ACK, b1[i][3:0], 0, 0, 1,
                               8'h10 + i[7:0]);
    tx(ack_buf_pkg::EV_ACK, 4'hf, 0, 0, 1, 8'h77);
    for (i = 0; i < 6; i++) pop_check(b1[i], 8'h10 + i[7:0],
                                      3'(6 - i));
    axi_rd(`OFF_TX_ACK_STAT);
    check("drained", rd, 32'h0);
    // busy codes only with an expired retry limit
    tx(ack_buf_pkg::EV_ACK, 4'hf, 0, 0, 0, 8'h20);
    tx(ack_buf_pkg::EV_ACK, 4'h4, 0, 0, 0, 8'h99);
    tx(ack_buf_pkg::EV_ACK, 4'h4, 0, 0, 1, 8'h21);
    tx(ack_buf_pkg::EV_ACK, 4'h5, 0, 0, 1, 8'h22);
    tx(ack_buf_pkg::EV_ACK, 4'h6, 0, 0, 1, 8'h23);
    tx(ack_buf_pkg::EV_NO_REPLY, 4'h0, 0, 0, 0, 8'h24);
    tx(ack_buf_pkg::EV_BAD_TCODE, 4'h0, 0, 0, 0, 8'h25);
    check("no flush", 32'(flush_seen), 32'h0);
    pop_check(`RES_ADDR_ERR, 8'h20, 3'd6);
    pop_check(`RES_BUSY_X, 8'h21, 3'd5);
    pop_check(`RES_BUSY_A, 8'h22, 3'd4);
    pop_check(`RES_BUSY_B, 8'h23, 3'd3);
    pop_check(`RES_NO_REPLY, 8'h24, 3'd2);
    pop_check(`RES_BAD_TCODE, 8'h25, 3'd1);
    // flush enable, odd events, half reads and bus refusals
    axi_wr(`OFF_TX_PATH_CFG, 32'h1);
    check("cfg resp", 32'(resp), 32'(`RESP_OKAY));
    axi_rd(`OFF_TX_PATH_CFG);
    check("cfg read", rd, 32'h1);
    tx(ack_buf_pkg::EV_BAD_TCODE, 4'h0, 0, 0, 0, 8'h30);
    check("flush", 32'(flush_seen), 32'h1);
    tx(ack_buf_pkg::EV_BAD_FORMAT, 4'h0, 0, 0, 0, 8'h31);
    tx(ack_buf_pkg::EV_ACK, 4'h1, 1, 0, 0, 8'h32);
    tx(ack_buf_pkg::EV_ACK, 4'hd, 0, 1, 0, 8'h33);
    for (i = 0; i < 2; i++) begin
      axi_rd(`OFF_TX_ACK_STAT + 12'h2);
      check("half", rd, ew(`RES_BAD_TCODE, 8'h30, 3'd4));
    end
    pop_check(`RES_BAD_TCODE, 8'h30, 3'd4);
    axi_wr(`OFF_TX_ACK_STAT, 32'hffff_ffff);
    check("ro resp", 32'(resp), 32'(`RESP_OKAY));
    axi_rd(12'h3f0);
    check("unmapped", {rd[29:0], resp}, {30'h0, `RESP_SLVERR});
    pop_check(`RES_BAD_FORMAT, 8'h31, 3'd3);
    pop_check(`RES_UNCLASSIFIED, 8'h32, 3'd2);
    // reset while an entry is still held
    @(posedge clk);
    arst_n <= 0;
    repeat (5) @(posedge clk);
    arst_n <= 1;
    axi_rd(`OFF_TX_ACK_STAT);
    check("after reset", rd, 32'h0);
    tx(ack_buf_pkg::EV_ACK, 4'hd, 0, 1, 0, 8'h40);
    pop_check(`RES_COMPLETE, 8'h40, 3'd1);
    stop_test();
  end
endmodule
